//--- design/sorc_pkg.sv
// constants, types and register map of the safety output restart control
package sorc_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  // automatic restart delay reset value
  localparam int unsigned AUTO_DLY_MS = 500;
  localparam logic [31:0] AUTO_DLY_RST = 32'(AUTO_DLY_MS * CYC_PER_MS);
  // half period of the flashing reset indicator
  localparam int unsigned FLASH_HALF_MS = 250;
  localparam logic [31:0] FLASH_HALF_RST = 32'(FLASH_HALF_MS * CYC_PER_MS);
  // contactor drop-out time before feedback is checked
  localparam int unsigned EDM_CHK_MS = 300;
  localparam int unsigned EDM_CHK_CYC = EDM_CHK_MS * CYC_PER_MS;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_AUTO_DLY = 4'h4;
  localparam logic [3:0] ADDR_FLASH = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hc;

  // ---------------------------------------------------------------
  // non-safe output indices
  // ---------------------------------------------------------------
  localparam int NS_N = 4;
  localparam int NS_ERR = 0;
  localparam int NS_RSTREQ = 1;
  localparam int NS_FLASH = 2;
  localparam int NS_FIELD = 3;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_IMMEDIATE = 2'h0,
    MODE_INTERLOCK = 2'h1,
    MODE_AUTO = 2'h2
  } sorc_mode_t;

  // gray along off -> clear -> on, lock beside
  typedef enum logic [1:0] {
    ST_OFF = 2'h0,
    ST_CLEAR = 2'h1,
    ST_ON = 2'h3,
    ST_LOCK = 2'h2
  } sorc_state_t;

  // control register, bit 0 upward: mode, feedback enable, polarity
  typedef struct packed {
    logic [NS_N-1:0] pol_low;
    logic edm_en;
    sorc_mode_t mode;
  } sorc_ctrl_t;
  localparam int CTRL_W = $bits(sorc_ctrl_t);
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h01;

  // status register, bit 15 downward
  typedef struct packed {
    logic [7:0] case_sel;
    logic edm_fb;
    logic obj;
    logic sleep;
    logic tripped;
    logic app_lat;
    logic safety_switch_output_pair;
    sorc_state_t state;
  } sorc_stat_t;

endpackage

//--- design/sorc_top.sv
// safety switching output pair with restart interlock, feedback check and indicators
`timescale 1ns/1ns
// How it works
// - device error forces all safety outputs off and enters the locking state
// - locking state left only by complete restart once the error has gone
// - application error forces safety outputs off without locking
// - after application error is gone, outputs stay off until a reset restart
// - steady reset indicator on while interlock tripped and field clear
// - flashing reset indicator toggles under the same tripped-and-clear condition
// - field indicator active while an object is in the active field
// - reset input clears the restart interlock so outputs may return on
// - sleep pushbutton places the device into sleep mode
// - restart input triggers a full restart, which also clears locking
// - pause input stops recording of the event history
// - immediate mode: output pair on as soon as the field is clear
// - interlock mode: output pair on only on reset or restart input
// - automatic mode: output pair on after configured delay of clear field
// - feedback enabled: after switching off, check feedback input is active
// - feedback inactive after switch-off: lock and keep outputs off
// - active-high setting: output idles low, high while signal active
// - active-low setting: output idles high, low while signal active
// - safety output is a dual-channel pair, off removes the danger
module sorc_top
  import sorc_pkg::*;
#(
  parameter int CASE_W = 6,
  parameter int unsigned EDM_CHK = EDM_CHK_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // field evaluation and diagnostics
  input wire logic obj_in_field_i,
  input wire logic device_err_i,
  input wire logic app_err_i,
  // local input pins
  input wire logic contactor_feedback_check_i,
  input wire logic reset_btn_i,
  input wire logic sleep_btn_i,
  input wire logic restart_btn_i,
  input wire logic pause_btn_i,
  input wire logic [CASE_W-1:0] case_sel_i,
  // safety switching output pair
  output logic safety_switch_output_pair_a_o,
  output logic safety_switch_output_pair_b_o,
  // non-safe outputs
  output logic [NS_N-1:0] nonsafe_o,
  output logic sleep_mode_o,
  output logic rec_pause_o,
  output logic dev_restart_o,
  output logic locked_o,
  output logic [CASE_W-1:0] case_sel_o
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // rising edge of a level sampled once per clock
  // prev comes from a flop cleared by reset, so a pin held high
  // through reset gives one edge on the first clock after release
  function automatic logic rise(input logic now, input logic prev);
    return now & ~prev;
  endfunction

  // saturating count: stops at the limit so it never wraps back to zero
  function automatic logic [31:0] cnt_inc(input logic [31:0] c, input logic [31:0] lim);
    return (c >= lim) ? c : c + 32'h1;
  endfunction

  localparam logic [31:0] EDM_LIM = 32'(EDM_CHK);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  sorc_ctrl_t ctrl_ff;
  logic [31:0] auto_dly_ff;
  logic [31:0] flash_half_ff;
  sorc_state_t state_ff;
  sorc_state_t nxt_state;
  logic app_lat_ff;
  logic sleep_ff;
  logic rst_prev_ff;
  logic sleep_prev_ff;
  logic restart_prev_ff;
  logic [31:0] dly_cnt_ff;
  logic [31:0] off_cnt_ff;
  logic [31:0] flash_cnt_ff;
  logic flash_ff;
  logic safety_switch_output_pair_a_ff;
  logic safety_switch_output_pair_b_ff;
  logic [NS_N-1:0] nonsafe_ff;
  logic rec_pause_ff;
  logic dev_restart_ff;
  logic locked_ff;
  logic [CASE_W-1:0] case_sel_ff;
  logic wait_ff;
  logic [31:0] rdata_ff;
  // interlock tripped and field clear, shared by status and indicators
  logic tripped;

  // ---------------------------------------------------------------
  // input events
  // ---------------------------------------------------------------
  wire rst_rise = rise(reset_btn_i, rst_prev_ff);
  wire sleep_rise = rise(sleep_btn_i, sleep_prev_ff);
  wire restart_rise = rise(restart_btn_i, restart_prev_ff);
  wire restart_ok = restart_rise & ~device_err_i;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rst_prev_ff <= 1'b0;
      sleep_prev_ff <= 1'b0;
      restart_prev_ff <= 1'b0;
    end else begin
      rst_prev_ff <= reset_btn_i;
      sleep_prev_ff <= sleep_btn_i;
      restart_prev_ff <= restart_btn_i;
    end
  end

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  // one fixed wait cycle: waitrequest drops on the edge a request
  // is seen and rises again at the edge that completes it
  // read data are loaded on the first edge and stand at the second
  wire bus_req = avs_read_i | avs_write_i;
  wire bus_ack = bus_req & ~wait_ff;
  wire bus_wr = avs_write_i & bus_ack;
  wire bus_rd_load = avs_read_i & wait_ff;
  wire wr_ctrl = bus_wr & (avs_address_i == ADDR_CTRL);
  wire wr_dly = bus_wr & (avs_address_i == ADDR_AUTO_DLY);
  wire wr_flash = bus_wr & (avs_address_i == ADDR_FLASH);

  sorc_stat_t stat;
  assign stat.case_sel = 8'(case_sel_ff);
  assign stat.edm_fb = contactor_feedback_check_i;
  assign stat.obj = obj_in_field_i;
  assign stat.sleep = sleep_ff;
  assign stat.tripped = tripped;
  assign stat.app_lat = app_lat_ff;
  assign stat.safety_switch_output_pair = safety_switch_output_pair_a_ff;
  assign stat.state = state_ff;

  logic [31:0] rd_mux;
  always_comb begin
    case (avs_address_i)
      ADDR_CTRL: rd_mux = 32'(ctrl_ff);
      ADDR_AUTO_DLY: rd_mux = auto_dly_ff;
      ADDR_FLASH: rd_mux = flash_half_ff;
      ADDR_STATUS: rd_mux = 32'(stat);
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0;
    end else begin
      wait_ff <= ~(bus_req & wait_ff);
      if (bus_rd_load) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_ff <= sorc_ctrl_t'(CTRL_RST);
      auto_dly_ff <= AUTO_DLY_RST;
      flash_half_ff <= FLASH_HALF_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= sorc_ctrl_t'(avs_writedata_i[CTRL_W-1:0]);
      end
      if (wr_dly) begin
        auto_dly_ff <= avs_writedata_i;
      end
      if (wr_flash) begin
        flash_half_ff <= avs_writedata_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // restart interlock state machine
  // ---------------------------------------------------------------
  // off -> clear -> on is the only way up; every fault drops to off or lock
  // lock is left only by a restart edge while no device error is present
  // anything that holds the pair off regardless of the field
  wire force_off = device_err_i | app_err_i | app_lat_ff | sleep_ff;
  wire obj = obj_in_field_i;
  wire dly_done = dly_cnt_ff >= auto_dly_ff;
  wire edm_fail = ctrl_ff.edm_en & (state_ff != ST_ON) & (off_cnt_ff >= EDM_LIM)
                  & ~contactor_feedback_check_i;

  logic release_ok;
  always_comb begin
    case (ctrl_ff.mode)
      MODE_IMMEDIATE: release_ok = 1'b1;
      MODE_INTERLOCK: release_ok = rst_rise | restart_rise;
      MODE_AUTO: release_ok = dly_done;
      default: release_ok = 1'b0;
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_LOCK: begin
        if (restart_ok) begin
          nxt_state = ST_OFF;
        end
      end
      ST_OFF: begin
        if (device_err_i | edm_fail) begin
          nxt_state = ST_LOCK;
        end else if (~obj & ~force_off) begin
          nxt_state = ST_CLEAR;
        end
      end
      ST_CLEAR: begin
        if (device_err_i | edm_fail) begin
          nxt_state = ST_LOCK;
        end else if (obj | force_off) begin
          nxt_state = ST_OFF;
        end else if (release_ok) begin
          nxt_state = ST_ON;
        end
      end
      ST_ON: begin
        if (device_err_i) begin
          nxt_state = ST_LOCK;
        end else if (obj | force_off) begin
          nxt_state = ST_OFF;
        end
      end
      default: nxt_state = ST_LOCK;
    endcase
  end

  // interlock tripped and field clear again
  assign tripped = (state_ff == ST_CLEAR) & (ctrl_ff.mode == MODE_INTERLOCK);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_ff <= ST_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // application error stays latched until a reset or restart once its cause is gone
  // error and clear in one cycle: the error wins
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      app_lat_ff <= 1'b0;
    end else if (app_err_i) begin
      app_lat_ff <= 1'b1;
    end else if (rst_rise | restart_rise) begin
      app_lat_ff <= 1'b0;
    end
  end

  // sleep toggles on each press, a full restart wakes the device
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sleep_ff <= 1'b0;
    end else if (sleep_rise) begin
      sleep_ff <= ~sleep_ff;
    end else if (restart_rise) begin
      sleep_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // timers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dly_cnt_ff <= 32'h0;
      off_cnt_ff <= 32'h0;
    end else begin
      if ((state_ff == ST_CLEAR) & ~obj) begin
        dly_cnt_ff <= cnt_inc(dly_cnt_ff, auto_dly_ff);
      end else begin
        dly_cnt_ff <= 32'h0;
      end
      if (safety_switch_output_pair_a_ff) begin
        off_cnt_ff <= 32'h0;
      end else begin
        off_cnt_ff <= cnt_inc(off_cnt_ff, EDM_LIM);
      end
    end
  end

  // flash restarts lit whenever the tripped condition begins
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flash_cnt_ff <= 32'h0;
      flash_ff <= 1'b0;
    end else if (~tripped) begin
      flash_cnt_ff <= 32'h0;
      flash_ff <= 1'b1;
    end else if (flash_cnt_ff + 32'h1 >= flash_half_ff) begin
      flash_cnt_ff <= 32'h0;
      flash_ff <= ~flash_ff;
    end else begin
      flash_cnt_ff <= flash_cnt_ff + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // pair taken from the next state so it drops on the edge a fault is seen
  // both channels come from separate flops of the same decision
  wire pair_on = (nxt_state == ST_ON);
  wire [NS_N-1:0] ns_act;
  assign ns_act[NS_ERR] = device_err_i | app_err_i | app_lat_ff | (state_ff == ST_LOCK);
  assign ns_act[NS_RSTREQ] = tripped;
  assign ns_act[NS_FLASH] = tripped & flash_ff;
  assign ns_act[NS_FIELD] = obj;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      safety_switch_output_pair_a_ff <= 1'b0;
      safety_switch_output_pair_b_ff <= 1'b0;
      nonsafe_ff <= '0;
      rec_pause_ff <= 1'b0;
      dev_restart_ff <= 1'b0;
      locked_ff <= 1'b0;
      case_sel_ff <= '0;
    end else begin
      safety_switch_output_pair_a_ff <= pair_on;
      safety_switch_output_pair_b_ff <= pair_on;
      nonsafe_ff <= ns_act ^ ctrl_ff.pol_low;
      rec_pause_ff <= pause_btn_i;
      dev_restart_ff <= restart_rise;
      locked_ff <= (nxt_state == ST_LOCK);
      case_sel_ff <= case_sel_i;
    end
  end

  // ---------------------------------------------------------------
  // port drive, all from flops
  // ---------------------------------------------------------------
  assign avs_readdata_o = rdata_ff;
  assign avs_waitrequest_o = wait_ff;
  assign safety_switch_output_pair_a_o = safety_switch_output_pair_a_ff;
  assign safety_switch_output_pair_b_o = safety_switch_output_pair_b_ff;
  assign nonsafe_o = nonsafe_ff;
  assign sleep_mode_o = sleep_ff;
  assign rec_pause_o = rec_pause_ff;
  assign dev_restart_o = dev_restart_ff;
  assign locked_o = locked_ff;
  assign case_sel_o = case_sel_ff;

endmodule

//--- test/sorc_monitor.sv
// port assertions of the safety output restart control
`timescale 1ns/1ns
module sorc_monitor
  import sorc_pkg::*;
#(
  parameter int CASE_W = 6
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // inputs
  input wire logic obj_in_field_i,
  input wire logic device_err_i,
  input wire logic app_err_i,
  input wire logic restart_btn_i,
  input wire logic pause_btn_i,
  // outputs
  input wire logic avs_waitrequest_o,
  input wire logic safety_switch_output_pair_a_o,
  input wire logic safety_switch_output_pair_b_o,
  input wire logic sleep_mode_o,
  input wire logic rec_pause_o,
  input wire logic dev_restart_o,
  input wire logic locked_o
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  dev_err_off_a: assert property (device_err_i |=> !safety_switch_output_pair_a_o)
    else $error("pair on after device error");
  app_err_off_a: assert property (app_err_i |=> !safety_switch_output_pair_a_o)
    else $error("pair on after application error");
  pair_match_a: assert property (safety_switch_output_pair_a_o == safety_switch_output_pair_b_o)
    else $error("pair channels differ");
  lock_off_a: assert property (locked_o && $past(locked_o) |-> !safety_switch_output_pair_a_o)
    else $error("pair on while locked");
  lock_exit_a: assert property ($fell(locked_o) |-> $past(restart_btn_i) || $past(restart_btn_i, 2))
    else $error("lock left without restart");
  pause_copy_a: assert property (rec_pause_o == $past(pause_btn_i))
    else $error("pause output not following input");
  restart_pulse_a: assert property ($rose(restart_btn_i) |-> ##[1:2] dev_restart_o)
    else $error("no restart pulse");
  pulse_width_a: assert property (dev_restart_o |=> !dev_restart_o)
    else $error("restart pulse too long");
  on_clear_a: assert property ($rose(safety_switch_output_pair_a_o) |-> !$past(obj_in_field_i, 2))
    else $error("pair on with object in field");
  sleep_off_a: assert property (sleep_mode_o && $past(sleep_mode_o) |-> !safety_switch_output_pair_a_o)
    else $error("pair on in sleep");
  wait_one_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  lock_c: cover property ($rose(locked_o));
  pair_on_c: cover property ($rose(safety_switch_output_pair_a_o));
  sleep_c: cover property ($rose(sleep_mode_o));
endmodule

bind sorc_top sorc_monitor #(.CASE_W(CASE_W)) u_mon (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .obj_in_field_i(obj_in_field_i),
  .device_err_i(device_err_i), .app_err_i(app_err_i), .restart_btn_i(restart_btn_i),
  .pause_btn_i(pause_btn_i), .avs_waitrequest_o(avs_waitrequest_o),
  .safety_switch_output_pair_a_o(safety_switch_output_pair_a_o),
  .safety_switch_output_pair_b_o(safety_switch_output_pair_b_o), .sleep_mode_o(sleep_mode_o),
  .rec_pause_o(rec_pause_o), .dev_restart_o(dev_restart_o), .locked_o(locked_o)
);

//--- test/sorc_contactor_model.sv
// contactor pair with auxiliary feedback contact
`timescale 1ns/1ns
module sorc_contactor_model #(
  parameter int DROP = 3
) (
  // coil and fault
  input wire logic clk_i,
  input wire logic coil_i,
  input wire logic weld_i,
  // feedback
  output logic fb_o
);
  int cnt = 0;
  // feedback closes only after drop-out, never when welded
  always @(posedge clk_i) begin
    if (coil_i) cnt <= 0;
    else if (cnt < DROP) cnt <= cnt + 1;
  end
  assign fb_o = !weld_i && !coil_i && (cnt >= DROP);
endmodule

//--- test/safety_output_restart_control_test.sv
// self-checking bench of the safety output restart control
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module safety_output_restart_control_test;
  import sorc_pkg::*;
  localparam int P = 4;
  localparam int S = 5;
  localparam int L = 6;
  logic clk_i = 0;
  logic sys_rst_i = 1;
  logic [3:0] adr = 0;
  logic rd = 0;
  logic wr = 0;
  logic [31:0] wd = 0;
  logic obj = 1;
  logic derr = 0;
  logic aerr = 0;
  logic weld = 0;
  logic pause = 0;
  logic [2:0] btn = 0;
  logic [5:0] csel = 6'h2a;
  logic [31:0] rdata, q;
  logic wreq, fb, pa, pb, slp, pau, drs, lck;
  logic [3:0] ns;
  logic [5:0] cso;
  wire logic [6:0] obs = {lck, slp, pa, ns};
  int error_cnt = 0;
  int total_checks = 0;

  sorc_top #(.CASE_W(6), .EDM_CHK(8)) dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .obj_in_field_i(obj),
    .device_err_i(derr), .app_err_i(aerr), .contactor_feedback_check_i(fb), .reset_btn_i(btn[0]),
    .sleep_btn_i(btn[1]), .restart_btn_i(btn[2]), .pause_btn_i(pause), .case_sel_i(csel),
    .safety_switch_output_pair_a_o(pa), .safety_switch_output_pair_b_o(pb), .nonsafe_o(ns),
    .sleep_mode_o(slp), .rec_pause_o(pau), .dev_restart_o(drs), .locked_o(lck), .case_sel_o(cso)
  );
  sorc_contactor_model u_cont (.clk_i(clk_i), .coil_i(pa | pb), .weld_i(weld), .fb_o(fb));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {adr, wd, wr, rd} <= {a, d, w, !w};
    n = 0;
    do begin @(posedge clk_i); n++; end while (wreq !== 1'b0 && n < 50);
    q = rdata;
    {wr, rd} <= 2'h0;
    if (n >= 50) begin error_cnt++; print_verdict; end
  endtask
  task automatic await(input int i, input logic v, input int m);
    int n;
    n = 0;
    do begin @(negedge clk_i); n++; end while (obs[i] !== v && n < m);
    `CHK(obs[i], v)
    if (obs[i] !== v) print_verdict;
  endtask
  task automatic hold(input int i, input logic v, input int m);
    repeat (m) begin @(negedge clk_i); `CHK(obs[i], v) end
  endtask
  task automatic press(input int k);
    @(posedge clk_i) btn[k] <= 1'b1;
    tick(3);
    btn[k] <= 1'b0;
    tick(2);
  endtask

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    tick(6);
    sys_rst_i <= 1'b0;
    bus(0, ADDR_CTRL, 0); `CHK(q, {25'h0, CTRL_RST})
    bus(0, ADDR_AUTO_DLY, 0); `CHK(q, AUTO_DLY_RST)
    bus(0, ADDR_FLASH, 0); `CHK(q, FLASH_HALF_RST)
    bus(0, 4'h2, 0); `CHK(q, 32'h0)
    bus(0, ADDR_STATUS, 0); `CHK({q[15:8], q[6], q[2:0]}, {2'h0, csel, 4'h8})
    `CHK(cso, csel)
    bus(1, ADDR_FLASH, 32'h4);
    @(posedge clk_i) pause <= 1'b1;
    await(3, 1, 5);
    @(posedge clk_i) obj <= 1'b0;
    hold(P, 0, 12);
    `CHK({ns[3], ns[1:0], pau}, 4'h5)
    await(2, 0, 10);
    await(2, 1, 10);
    press(0);
    await(P, 1, 5);
    @(posedge clk_i) pause <= 1'b0;
    bus(1, ADDR_CTRL, 0);
    @(posedge clk_i) obj <= 1'b1;
    await(P, 0, 4);
    @(posedge clk_i) obj <= 1'b0;
    await(P, 1, 3);
    @(posedge clk_i) aerr <= 1'b1;
    await(P, 0, 3);
    `CHK(lck, 1'b0)
    @(posedge clk_i) aerr <= 1'b0;
    hold(P, 0, 10);
    press(0);
    await(P, 1, 5);
    bus(1, ADDR_AUTO_DLY, 32'd20);
    bus(1, ADDR_CTRL, 32'h2);
    @(posedge clk_i) obj <= 1'b1;
    await(P, 0, 4);
    @(posedge clk_i) obj <= 1'b0;
    hold(P, 0, 10);
    @(posedge clk_i) obj <= 1'b1;
    @(posedge clk_i) obj <= 1'b0;
    hold(P, 0, 15);
    await(P, 1, 10);
    press(1);
    await(S, 1, 5);
    await(P, 0, 3);
    press(1);
    await(S, 0, 5);
    @(posedge clk_i) derr <= 1'b1;
    await(L, 1, 5);
    `CHK(pa, 1'b0)
    @(posedge clk_i) derr <= 1'b0;
    press(0);
    hold(L, 1, 5);
    press(2);
    await(L, 0, 5);
    bus(1, ADDR_CTRL, 32'h41);
    @(posedge clk_i) obj <= 1'b1;
    await(3, 0, 5);
    @(posedge clk_i) obj <= 1'b0;
    await(3, 1, 5);
    bus(1, ADDR_CTRL, 32'h4);
    await(P, 1, 5);
    @(posedge clk_i) obj <= 1'b1;
    hold(L, 0, 20);
    @(posedge clk_i) obj <= 1'b0;
    await(P, 1, 5);
    @(posedge clk_i) {weld, obj} <= 2'h3;
    await(L, 1, 30);
    @(posedge clk_i) obj <= 1'b0;
    hold(P, 0, 5);
    @(posedge clk_i) sys_rst_i <= 1'b1;
    tick(2);
    sys_rst_i <= 1'b0;
    @(negedge clk_i) `CHK({lck, pa}, 2'h0)
    bus(0, ADDR_CTRL, 0); `CHK(q, {25'h0, CTRL_RST})
    bus(1, ADDR_CTRL, 32'h3);
    hold(P, 0, 10);
    print_verdict;
  end
endmodule
